/* shared/pgpio_map.svh */
/*
 * Constants of the port pin function block: line population, fixed
 * line positions and widths.
 * Assumes ports 0 to 22, eight bit positions per port, port p at bits 8p+7:8p.
 */
`ifndef PGPIO_MAP_SVH
`define PGPIO_MAP_SVH

// ============================================================
// Geometry
`define PGPIO_NUM_PORTS 23
`define PGPIO_LINES_PER_PORT 8
`define PGPIO_NUM_LINES 157

// ============================================================
// Population, port 22 in the top byte, port 0 in the bottom byte
`define PGPIO_LINE_MASK 184'h3f_ff_0f_ff_ff_fc_ff_ff_ff_ff_f0_ff_ff_f8_fc_ff_fe_00_fe_ff_ff_ff_ff

// ============================================================
// Lines that can never drive (break interrupt input, CAN receive)
`define PGPIO_BRK_IN_BIT 52
`define PGPIO_CAN_RX_BIT 177

// ============================================================
// Lines taken over by the external bus in extended or processor mode
`define PGPIO_BUS_LINE_MASK 184'h30_00_00_00_00_00_00_00_00_00_00_00_00_00_00_00_00_00_ff_ff_ff_ff_ff

// ============================================================
// Value returned for a blocked input line
`define PGPIO_BLOCKED_VAL 1'b0

`endif

/* shared/pgpio_pkg.sv */
/*
 * Types of the port pin function block.
 * Assumes nothing of its surroundings.
 */
package pgpio_pkg;

	// ============================================================
	// CPU operation mode from the two mode-select pins
	typedef enum logic [1:0] {
		pgpio_single_chip,
		pgpio_ext_external,
		pgpio_processor,
		pgpio_reserved
	} pgpio_mode_t;

endpackage : pgpio_pkg

/* shared/pgpio_mode_if.sv */
/*
 * Carries the decoded CPU operation mode from the decoder to the port logic.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface pgpio_mode_if;
	import pgpio_pkg::*;
	pgpio_mode_t mode;
	logic ext_bus;
	logic reserved;
	modport dec(output mode, output ext_bus, output reserved);
	modport user(input mode, input ext_bus, input reserved);
endinterface : pgpio_mode_if

/* verilog/pgpio_mode_dec.sv */
/*
 * Decoder of the two mode-select pins into the CPU operation mode.
 * Assumes the pins are static and synchronous to the core clock.
 */
`timescale 1ns/100ps
module pgpio_mode_dec
	import pgpio_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_mode_select_pin_a,
	input wire logic i_mode_select_pin_b,
	pgpio_mode_if.dec o_mode
);

	pgpio_mode_t mode_reg;
	pgpio_mode_t mode_next;

	// ============================================================
	// Decode
	always_comb begin
		case ({i_mode_select_pin_a, i_mode_select_pin_b})
			2'h0: mode_next = pgpio_single_chip;
			2'h1: mode_next = pgpio_ext_external;
			2'h2: mode_next = pgpio_processor;
			default: mode_next = pgpio_reserved;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			mode_reg <= pgpio_single_chip;
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign o_mode.mode = mode_reg;
	assign o_mode.ext_bus = (mode_reg == pgpio_ext_external) || (mode_reg == pgpio_processor);
	assign o_mode.reserved = (mode_reg == pgpio_reserved);

	// ============================================================
	// Checks
	a_mode_decode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_mode_select_pin_a && !i_mode_select_pin_b |=> mode_reg == pgpio_processor)
		else $error("Mode pins 1,0 did not give processor mode");

endmodule : pgpio_mode_dec

/* verilog/pgpio_top.sv */
/*
 * Port pin function block: 157 port lines over ports 0 to 22, direction,
 * input blocking and pin function selection.
 * Assumes all inputs synchronous to i_core_clk; pad drivers outside resolve
 * the wire from o_pin_out and o_pin_oe.
 */
`timescale 1ns/100ps
`include "pgpio_map.svh"
module pgpio_top
	import pgpio_pkg::*;
#(
	parameter int NUM_PORTS = `PGPIO_NUM_PORTS,
	parameter int LINES_PER_PORT = `PGPIO_LINES_PER_PORT
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_port_input_enable_bit,
	input wire logic i_mode_select_pin_a,
	input wire logic i_mode_select_pin_b,
	input wire logic [NUM_PORTS*LINES_PER_PORT-1:0] i_port_dir,
	input wire logic [NUM_PORTS*LINES_PER_PORT-1:0] i_port_out_data,
	input wire logic [NUM_PORTS-1:0] i_port_periph_sel,
	input wire logic [NUM_PORTS*LINES_PER_PORT-1:0] i_periph_out,
	input wire logic [NUM_PORTS*LINES_PER_PORT-1:0] i_periph_oe,
	input wire logic [NUM_PORTS*LINES_PER_PORT-1:0] i_bus_out,
	input wire logic [NUM_PORTS*LINES_PER_PORT-1:0] i_bus_oe,
	input wire logic [NUM_PORTS*LINES_PER_PORT-1:0] i_pin_in,
	output logic [NUM_PORTS*LINES_PER_PORT-1:0] o_pin_out,
	output logic [NUM_PORTS*LINES_PER_PORT-1:0] o_pin_oe,
	output logic [NUM_PORTS*LINES_PER_PORT-1:0] o_port_rd_data,
	output logic [NUM_PORTS*LINES_PER_PORT-1:0] o_line_in,
	output logic o_ext_bus_mode,
	output logic o_mode_reserved
);

	localparam int W = NUM_PORTS * LINES_PER_PORT;
	localparam logic [W-1:0] LINE_MASK = `PGPIO_LINE_MASK;
	localparam logic [W-1:0] BUS_MASK = `PGPIO_BUS_LINE_MASK;

	// ============================================================
	// Elaboration checks
	if (NUM_PORTS != `PGPIO_NUM_PORTS || LINES_PER_PORT != `PGPIO_LINES_PER_PORT) begin : g_bad_geom
		$error("Line population is fixed at 23 ports of 8 positions");
	end
	if ($countones(LINE_MASK) != `PGPIO_NUM_LINES) begin : g_bad_count
		$error("Population mask does not hold 157 lines");
	end

	// Per-port select widened to every line of the port
	function automatic logic [W-1:0] spread_ports(input logic [NUM_PORTS-1:0] sel);
		logic [W-1:0] r;
		r = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			r[p*LINES_PER_PORT +: LINES_PER_PORT] = {LINES_PER_PORT{sel[p]}};
		end
		return r;
	endfunction : spread_ports

	function automatic logic [W-1:0] one_line(input int idx);
		logic [W-1:0] r;
		r = '0;
		r[idx] = 1'b1;
		return r;
	endfunction : one_line

	localparam logic [W-1:0] IN_ONLY_MASK = one_line(`PGPIO_BRK_IN_BIT) | one_line(`PGPIO_CAN_RX_BIT);
	// Ports 6 and up are steered by their own mode bit; port 0..4 and port 5 never
	localparam logic [W-1:0] OPMODE_PORTS = {{(W-6*8){1'b1}}, {(6*8){1'b0}}};

	// Fixed lines must sit inside the population
	if ((LINE_MASK & IN_ONLY_MASK) != IN_ONLY_MASK) begin : g_bad_in_only
		$error("Input-only lines must be populated");
	end
	if (LINE_MASK[47:40] != 8'h00) begin : g_bad_port5
		$error("Reserved port must hold no lines");
	end

	// ============================================================
	// Mode decode
	pgpio_mode_if mode_bus();

	pgpio_mode_dec u_mode_dec (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_mode_select_pin_a(i_mode_select_pin_a),
		.i_mode_select_pin_b(i_mode_select_pin_b),
		.o_mode(mode_bus.dec)
	);

	// ============================================================
	// Input enable, blocked from reset onward
	logic in_en_reg;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			in_en_reg <= 1'b0;
		end else begin
			in_en_reg <= i_port_input_enable_bit;
		end
	end

	// ============================================================
	// Function selection
	// Reserved mode pins fall back to single chip, flagged on o_mode_reserved
	wire [W-1:0] bus_lines = mode_bus.ext_bus ? BUS_MASK : '0;
	// Bus lines ignore the port mode bit so only the mode pins steer them
	wire [W-1:0] periph_lines = spread_ports(i_port_periph_sel) & OPMODE_PORTS & ~BUS_MASK;
	wire [W-1:0] port_lines = ~bus_lines & ~periph_lines;
	wire [W-1:0] drive_ok = LINE_MASK & ~IN_ONLY_MASK;
	wire [W-1:0] port_oe = i_port_dir & port_lines;
	wire [W-1:0] oe_mux = (i_bus_oe & bus_lines) | (i_periph_oe & periph_lines) | port_oe;
	wire [W-1:0] out_mux = (i_bus_out & bus_lines) | (i_periph_out & periph_lines) | (i_port_out_data & port_lines);
	wire [W-1:0] pin_oe_next = oe_mux & drive_ok;
	wire [W-1:0] pin_out_next = out_mux & drive_ok;

	// Pin level is gated before any flop, so a floating pin never toggles logic while the input enable is off
	wire [W-1:0] gated_in = in_en_reg ? (i_pin_in & LINE_MASK) : {W{`PGPIO_BLOCKED_VAL}};
	// Input-only lines drop out of the direction decode, so they read the gated pin level whatever their direction bit
	wire [W-1:0] is_input = ~(i_port_dir & drive_ok);
	wire [W-1:0] rd_next = ((gated_in & is_input) | (i_port_out_data & ~is_input)) & LINE_MASK;

	// ============================================================
	// Output flops
	logic [W-1:0] pin_oe_reg;
	logic [W-1:0] pin_out_reg;
	logic [W-1:0] rd_reg;
	logic [W-1:0] line_in_reg;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pin_oe_reg <= '0;
			pin_out_reg <= '0;
			rd_reg <= '0;
			line_in_reg <= '0;
		end else begin
			pin_oe_reg <= pin_oe_next;
			pin_out_reg <= pin_out_next;
			rd_reg <= rd_next;
			line_in_reg <= gated_in;
		end
	end

	assign o_pin_oe = pin_oe_reg;
	assign o_pin_out = pin_out_reg;
	assign o_port_rd_data = rd_reg;
	assign o_line_in = line_in_reg;
	assign o_ext_bus_mode = mode_bus.ext_bus;
	assign o_mode_reserved = mode_bus.reserved;

	// ============================================================
	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// Registered outputs are checked one cycle after the inputs they follow

	a_in_blocked_reset: assert property (
		$rose(i_rst_n) ##0 !i_port_input_enable_bit [*2] |=> o_line_in == '0)
		else $error("Input path open after reset without enable");
	a_blocked_read_fixed: assert property (
		!in_en_reg |=> (o_port_rd_data & ~$past(i_port_dir)) == '0)
		else $error("Blocked input line did not read fixed value");
	a_unpopulated_idle: assert property (
		(o_pin_oe[47:40] | o_port_rd_data[47:40] | o_line_in[47:40]) == 8'h00)
		else $error("Reserved port became active");
	a_unpop_silent: assert property (
		((o_pin_oe | o_port_rd_data | o_line_in) & ~LINE_MASK) == '0)
		else $error("Unimplemented line became active");
	a_in_only_never: assert property (
		!o_pin_oe[`PGPIO_BRK_IN_BIT] && !o_pin_oe[`PGPIO_CAN_RX_BIT])
		else $error("Input-only line driven");
	a_dir_follows: assert property (
		!mode_bus.ext_bus && i_port_periph_sel == '0 |=> o_pin_oe == ($past(i_port_dir) & drive_ok))
		else $error("Port direction not applied");
	a_bus_takeover: assert property (
		mode_bus.ext_bus |=> (o_pin_oe & BUS_MASK) == ($past(i_bus_oe) & BUS_MASK & drive_ok))
		else $error("Bus lines not given to external bus");
	a_single_chip_port: assert property (
		mode_bus.mode == pgpio_single_chip |=> (o_pin_oe & BUS_MASK) == ($past(i_port_dir) & BUS_MASK & drive_ok))
		else $error("Bus lines not ports in single chip mode");
	a_periph_select: assert property (
		i_port_periph_sel[7] |=> o_pin_out[63:56] == $past(i_periph_out[63:56]))
		else $error("Port 7 peripheral function not selected");
	a_enabled_read: assert property (
		in_en_reg && !i_port_dir[0] |=> o_port_rd_data[0] == $past(i_pin_in[0]))
		else $error("Enabled input line did not read pin");

	// Bus lines, reserved mode, input-only lines and blocked inputs
	a_bus_out_value: assert property (
		mode_bus.ext_bus |=> (o_pin_out & BUS_MASK) == ($past(i_bus_out) & BUS_MASK & drive_ok))
		else $error("Bus lines not driven with bus value");
	a_reserved_ports: assert property (
		mode_bus.reserved |=> (o_pin_oe & BUS_MASK) == ($past(i_port_dir) & BUS_MASK & drive_ok))
		else $error("Reserved mode did not leave bus lines as ports");
	a_bus_pair_mode: assert property (
		!mode_bus.ext_bus && i_port_periph_sel[22] |=> o_pin_out[181:180] == $past(i_port_out_data[181:180]))
		else $error("Port 22 bus lines followed the port mode bit");
	a_in_only_read: assert property (
		in_en_reg && i_port_dir[`PGPIO_CAN_RX_BIT]
		|=> o_port_rd_data[`PGPIO_CAN_RX_BIT] == $past(i_pin_in[`PGPIO_CAN_RX_BIT]))
		else $error("Input-only line did not read its pin");
	a_line_in_blocked: assert property (
		!in_en_reg |=> o_line_in == '0)
		else $error("Blocked pin reached peripheral inputs");

	c_enable_input: cover property ($rose(in_en_reg) ##1 o_line_in != '0);
	c_ext_mode: cover property ($rose(mode_bus.ext_bus));
	c_periph_drive: cover property (i_port_periph_sel[7] ##1 o_pin_oe[56]);
	c_reserved_mode: cover property (o_mode_reserved);
	c_in_only_read: cover property (in_en_reg && i_port_dir[`PGPIO_BRK_IN_BIT]);

endmodule : pgpio_top

/* tb/pgpio_pin_model.sv */
/*
 * Board model of the pins: each wire shows the device drive while enabled,
 * otherwise the level the board puts on it.
 * Assumes the board holds every undriven wire at a defined level.
 */
`timescale 1ns/100ps
module pgpio_pin_model (
	input wire logic [183:0] i_drv_val,
	input wire logic [183:0] i_drv_en,
	input wire logic [183:0] i_board_level,
	output logic [183:0] o_pin_level
);
	// ============================================================
	// Wire resolution, device drive wins where enabled
	always_comb begin
		for (int i = 0; i < 184; i++) begin
			o_pin_level[i] = i_drv_en[i] ? i_drv_val[i] : i_board_level[i];
		end
	end
endmodule : pgpio_pin_model

/* tb/tb_port_io_pin_function_select.sv */
/*
 * Self-checking bench of the port pin function block.
 * Assumes the block and the pin model above; one 200 MHz clock.
 */
`timescale 1ns/100ps
`include "pgpio_map.svh"
module tb_port_io_pin_function_select;
	import pgpio_pkg::*;
	localparam int W = 184;
	localparam logic [W-1:0] MASK = `PGPIO_LINE_MASK;
	localparam logic [W-1:0] BUS = `PGPIO_BUS_LINE_MASK;
	localparam logic [W-1:0] FIXED = (184'h1 << `PGPIO_BRK_IN_BIT) | (184'h1 << `PGPIO_CAN_RX_BIT);
	localparam logic [W-1:0] ONES = {W{1'b1}};
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic in_en = 1'b0;
	logic mode_a = 1'b0;
	logic mode_b = 1'b0;
	logic [22:0] psel = 23'h0;
	logic [W-1:0] dir = '0, odat = '0, pout = '0, poe = '0, bout = '0, boe = '0, board = '0;
	logic [W-1:0] pin, o_out, o_oe, o_rd, o_lin;
	logic o_ext, o_res;
	int mismatches = 0;
	int check_count = 0;

	always #2.5 i_core_clk = ~i_core_clk;

	pgpio_top DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_port_input_enable_bit(in_en),
		.i_mode_select_pin_a(mode_a), .i_mode_select_pin_b(mode_b), .i_port_dir(dir),
		.i_port_out_data(odat), .i_port_periph_sel(psel), .i_periph_out(pout), .i_periph_oe(poe),
		.i_bus_out(bout), .i_bus_oe(boe), .i_pin_in(pin), .o_pin_out(o_out), .o_pin_oe(o_oe),
		.o_port_rd_data(o_rd), .o_line_in(o_lin), .o_ext_bus_mode(o_ext), .o_mode_reserved(o_res));

	pgpio_pin_model u_pins (.i_drv_val(o_out), .i_drv_en(o_oe), .i_board_level(board), .o_pin_level(pin));

	// ============================================================
	// Shared tasks
	task automatic check(input string name, input logic [W-1:0] exp, input logic [W-1:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Step past the edge so registered outputs have landed
	task automatic settle(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : settle

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	initial begin
		#20000;
		mismatches++;
		$display("watchdog expired");
		finish_test();
	end

	// ============================================================
	// Tests
	initial begin
		board = ONES;
		settle(20);
		check("oe in reset", '0, o_oe);
		@(posedge i_core_clk);
		i_rst_n <= 1'b1;
		settle(3);
		check("line in blocked", '0, o_lin);
		check("read blocked", '0, o_rd);
		$display("test blocked input done");
		@(posedge i_core_clk);
		in_en <= 1'b1;
		settle(3);
		check("line in enabled", MASK, o_lin);
		check("read enabled", MASK, o_rd);
		@(posedge i_core_clk);
		board <= {23{8'ha5}};
		settle(3);
		check("line in pattern", MASK & {23{8'ha5}}, o_lin);
		check("read pattern", MASK & {23{8'ha5}}, o_rd);
		@(posedge i_core_clk);
		board <= ONES;
		$display("test input enable done");
		@(posedge i_core_clk);
		dir <= ONES;
		odat <= ONES;
		settle(3);
		check("drive oe", MASK & ~FIXED, o_oe);
		check("drive out", MASK & ~FIXED, o_out);
		@(posedge i_core_clk);
		dir <= {23{8'h55}};
		settle(3);
		check("mixed oe", MASK & ~FIXED & {23{8'h55}}, o_oe);
		$display("test direction done");
		@(posedge i_core_clk);
		dir <= ONES;
		psel <= {23{1'b1}};
		poe <= ONES;
		pout <= '0;
		settle(3);
		check("periph out", MASK & BUS, o_out);
		check("periph oe", MASK & ~FIXED, o_oe);
		@(posedge i_core_clk);
		psel <= 23'h0;
		boe <= ONES;
		bout <= '0;
		for (int m = 0; m < 4; m++) begin
			@(posedge i_core_clk);
			mode_a <= m[1];
			mode_b <= m[0];
			settle(4);
			check("ext bus", {183'h0, m == 1 || m == 2}, {183'h0, o_ext});
			check("reserved", {183'h0, m == 3}, {183'h0, o_res});
			check("mode out", (m == 1 || m == 2) ? MASK & ~BUS & ~FIXED : MASK & ~FIXED, o_out);
		end
		$display("test modes done");
		@(posedge i_core_clk);
		mode_a <= 1'b0;
		mode_b <= 1'b0;
		dir <= '0;
		in_en <= 1'b0;
		settle(3);
		@(posedge i_core_clk);
		board <= '0;
		settle(2);
		@(posedge i_core_clk);
		board <= ONES;
		settle(2);
		check("line in blocked again", '0, o_lin);
		check("read blocked again", '0, o_rd);
		$display("test disable done");
		finish_test();
	end
endmodule : tb_port_io_pin_function_select
